// [hdl/ail_host_end.sv]
// Host adapter interrupt logic with Wishbone register slave and single host interrupt
//
// The address map and the Wishbone register port were decided locally.
module ail_host_end
   import ail_pkg::*;
(
   input  wire logic        clk_i,           // System clock
   input  wire logic        rst_i,           // Synchronous reset, active high
   input  wire logic        wb_cyc_i,        // Wishbone cycle
   input  wire logic        wb_stb_i,        // Wishbone strobe
   input  wire logic        wb_we_i,         // Wishbone write enable
   input  wire logic [7:0]  wb_adr_i,        // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,        // Wishbone byte selects
   input  wire logic [31:0] wb_dat_i,        // Wishbone write data
   output logic      [31:0] wb_dat_o,        // Wishbone read data
   output logic             wb_ack_o,        // Wishbone acknowledge
   output logic             inta_n_o,        // Host interrupt, active low
   input  wire logic        xfer_start_i,    // Host-to-remote transfer begins, pulse
   input  wire logic        xfer_done_i,     // Host-to-remote transfer completes, pulse
   input  wire logic        data_error_i,    // Corrupted data seen on the link, pulse
   input  wire logic        dma_done_i,      // DMA operation finished, pulse
   ail_link_if.host_mp      link             // Cable toward the remote adapter
);

   // Register state
   logic [2:0]       db_sel_reg;         // Outbound doorbell line code
   logic             err_en_reg;         // Error interrupt enable
   logic             norm_en_reg;        // Normal interrupt enable
   logic             send_db_reg;        // Outbound doorbell asserted
   logic             rxdb_reg;           // Incoming receiver doorbell latched
   logic             bus_err_reg;        // Remote bus error latched
   logic             tmo_reg;            // Interface timeout latched
   logic             data_err_reg;       // Data error latched
   logic [2:0]       iack_lvl_reg;       // Level to acknowledge
   logic             dma_done_reg;       // DMA done flag
   logic             dma_en_reg;         // DMA done interrupt enable
   logic             irq_reg;            // Interrupt being asserted
   logic             ack_reg;            // Bus acknowledge
   logic [31:0]      rdata_reg;          // Latched read data
   logic             busy_reg;           // Remote transfer in flight
   logic [TMO_W-1:0] tmo_cnt_reg;        // Cycles spent in the transfer
   logic             txdb_ack_reg;       // Transmitter doorbell acknowledge pulse
   logic             rxdb_out_reg;       // Receiver doorbell toward remote
   logic             iack_stb_reg;       // Acknowledge strobe toward remote

   // Bus decode and interrupt merge
   logic             req;                // Request present
   logic             fire;               // Edge at which the master takes the answer
   logic             wr_b0;              // Write touching the low byte
   logic [7:0]       wb0;                // Low byte of write data
   logic [7:0]       rd_byte;            // Read value before latching
   logic             err_any;            // Any latched error
   logic             norm_any;           // Any normal source pending
   logic             irq_next;           // Next interrupt state

   assign req   = wb_cyc_i & wb_stb_i;
   assign fire  = req & ack_reg;
   assign wr_b0 = fire & wb_we_i & wb_sel_i[0];
   assign wb0   = wb_dat_i[7:0];

   // Answer every request one cycle after it appears, for one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      rd_byte = RST_BYTE;
      if (wb_adr_i == OFS_INT_CTRL) begin
         rd_byte = {irq_reg, norm_en_reg, err_en_reg, 2'b00, db_sel_reg};
      end else if (wb_adr_i == OFS_INT_STATUS) begin
         rd_byte = {link.r2h_cable_irq_line, 1'b0};
      end else if (wb_adr_i == OFS_LOCAL_CMD) begin
         rd_byte = {2'b00, send_db_reg, 5'h00};
      end else if (wb_adr_i == OFS_LOCAL_STAT) begin
         rd_byte = {2'b00, rxdb_reg, 2'b00, data_err_reg, tmo_reg, bus_err_reg};
      end else if (wb_adr_i == OFS_REMOTE_CMD1) begin
         rd_byte = {5'h00, iack_lvl_reg};
      end else if (wb_adr_i == OFS_REMOTE_STAT) begin
         rd_byte = {6'h00, link.r2h_tx_doorbell, link.r2h_rx_doorbell_pend};
      end else if (wb_adr_i == OFS_IACK_LOW) begin
         rd_byte = {5'h00, iack_lvl_reg};
      end else if (wb_adr_i == OFS_DMA_CMD) begin
         rd_byte = {5'h00, dma_en_reg, dma_done_reg, 1'b0};
      end
   end

   // Latch read data as the answer is raised
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= RST_WORD;
      end else if (req & ~ack_reg & ~wb_we_i) begin
         rdata_reg <= {24'h000000, rd_byte};
      end else if (~req) begin
         rdata_reg <= RST_WORD;
      end
   end

   // Interrupt control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         db_sel_reg  <= 3'h0;
         err_en_reg  <= 1'b0;
         norm_en_reg <= 1'b0;
      end else if (wr_b0 && wb_adr_i == OFS_INT_CTRL) begin
         db_sel_reg  <= wb0[IC_SEL_LSB +: 3];
         err_en_reg  <= wb0[IC_ERR_EN];
         norm_en_reg <= wb0[IC_NORM_EN];
      end
   end

   // Outbound doorbell: held while local command bit 5 is set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         send_db_reg <= 1'b0;
      end else if (wr_b0 && wb_adr_i == OFS_LOCAL_CMD) begin
         send_db_reg <= wb0[LC_SEND_DB];
      end
   end

   // Incoming receiver doorbell; a new arrival wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxdb_reg <= 1'b0;
      end else if (link.r2h_rx_doorbell) begin
         rxdb_reg <= 1'b1;
      end else if (wr_b0 && wb_adr_i == OFS_LOCAL_CMD && wb0[LC_CLR_RXDB]) begin
         rxdb_reg <= 1'b0;
      end
   end

   // Transfer watchdog: counts while a remote transfer is outstanding
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_reg    <= 1'b0;
         tmo_cnt_reg <= '0;
      end else if (xfer_start_i) begin
         busy_reg    <= 1'b1;
         tmo_cnt_reg <= '0;
      end else if (xfer_done_i || (busy_reg && tmo_cnt_reg == TMO_LIMIT - 12'h001)) begin
         busy_reg    <= 1'b0;
         tmo_cnt_reg <= '0;
      end else if (busy_reg) begin
         tmo_cnt_reg <= tmo_cnt_reg + 12'h001;
      end
   end

   // Latched error conditions; a fresh error wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_err_reg  <= 1'b0;
         tmo_reg      <= 1'b0;
         data_err_reg <= 1'b0;
      end else begin
         if (link.r2h_bus_error) begin
            bus_err_reg <= 1'b1;
         end else if (wr_b0 && wb_adr_i == OFS_LOCAL_CMD && wb0[LC_CLR_ERR]) begin
            bus_err_reg <= 1'b0;
         end
         if (busy_reg && !xfer_done_i && !xfer_start_i && tmo_cnt_reg == TMO_LIMIT - 12'h001) begin
            tmo_reg <= 1'b1;
         end else if (wr_b0 && wb_adr_i == OFS_LOCAL_CMD && wb0[LC_CLR_ERR]) begin
            tmo_reg <= 1'b0;
         end
         if (data_error_i) begin
            data_err_reg <= 1'b1;
         end else if (wr_b0 && wb_adr_i == OFS_LOCAL_CMD && wb0[LC_CLR_ERR]) begin
            data_err_reg <= 1'b0;
         end
      end
   end

   // Remote command one: acknowledge level, doorbell pulses toward remote
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         iack_lvl_reg <= 3'h0;
         rxdb_out_reg <= 1'b0;
         txdb_ack_reg <= 1'b0;
      end else begin
         txdb_ack_reg <= 1'b0;
         rxdb_out_reg <= 1'b0;
         if (wr_b0 && wb_adr_i == OFS_REMOTE_CMD1) begin
            iack_lvl_reg <= wb0[RC_IACK_LSB +: 3];
            rxdb_out_reg <= wb0[RC_SEND_RXDB];
            txdb_ack_reg <= wb0[RC_ACK_TXDB];
         end
      end
   end

   // Each acknowledge read issues one acknowledge cycle at the remote
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         iack_stb_reg <= 1'b0;
      end else begin
         iack_stb_reg <= fire & ~wb_we_i & (wb_adr_i == OFS_IACK_LOW);
      end
   end

   // DMA command: completion flag set by hardware, cleared by writing zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dma_done_reg <= 1'b0;
         dma_en_reg   <= 1'b0;
      end else begin
         if (wr_b0 && wb_adr_i == OFS_DMA_CMD) begin
            dma_en_reg <= wb0[DC_DONE_EN];
         end
         if (dma_done_i) begin
            dma_done_reg <= 1'b1;
         end else if (wr_b0 && wb_adr_i == OFS_DMA_CMD && !wb0[DC_DONE]) begin
            dma_done_reg <= 1'b0;
         end
      end
   end

   // Source merge and enable gating
   assign err_any  = bus_err_reg | tmo_reg | data_err_reg;
   assign norm_any = rxdb_reg | link.r2h_tx_doorbell | (|link.r2h_cable_irq_line) |
                     (dma_done_reg & dma_en_reg);
   assign irq_next = (err_en_reg & err_any) | (norm_en_reg & norm_any);

   // Level interrupt: follows the gated sources each cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg  <= 1'b0;
         inta_n_o <= 1'b1;
      end else begin
         irq_reg  <= irq_next;
         inta_n_o <= ~irq_next;
      end
   end

   // Bus outputs
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // Cable outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link.h2r_cable_irq_line <= 7'h00;
      end else begin
         link.h2r_cable_irq_line <= send_db_reg ? ail_line_decode(db_sel_reg) : 7'h00;
      end
   end
   assign link.h2r_rx_doorbell     = rxdb_out_reg;
   assign link.h2r_tx_doorbell_ack = txdb_ack_reg;
   assign link.h2r_iack_stb        = iack_stb_reg;
   assign link.h2r_iack_level      = iack_lvl_reg;
endmodule

// [hdl/ail_pkg.sv]
// Package of constants, register map and helpers for the adapter interrupt logic
package ail_pkg;
   // Clock and timing
   localparam int          CLK_PERIOD_NS   = 10;     // System clock period in ns
   localparam int          XFER_TIMEOUT_US = 30;     // Remote transfer timeout in microseconds
   localparam int          XFER_TIMEOUT_CYC = (XFER_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          TMO_W           = 12;     // Width of the timeout counter
   localparam logic [11:0] TMO_LIMIT       = 12'(XFER_TIMEOUT_CYC);

   // Register byte offsets on the host bus
   localparam logic [7:0]  OFS_INT_CTRL    = 8'h00;  // Interrupt control
   localparam logic [7:0]  OFS_INT_STATUS  = 8'h04;  // Interrupt status (cable levels)
   localparam logic [7:0]  OFS_LOCAL_CMD   = 8'h08;  // Local command
   localparam logic [7:0]  OFS_LOCAL_STAT  = 8'h0C;  // Local status
   localparam logic [7:0]  OFS_REMOTE_CMD1 = 8'h10;  // Remote command one
   localparam logic [7:0]  OFS_REMOTE_STAT = 8'h14;  // Remote status
   localparam logic [7:0]  OFS_IACK_LOW    = 8'h18;  // Acknowledge read, low
   localparam logic [7:0]  OFS_DMA_CMD     = 8'h1C;  // DMA command

   // Interrupt control fields
   localparam int          IC_SEL_LSB      = 0;      // Doorbell cable line select, bits 2..0
   localparam int          IC_ERR_EN       = 5;      // Error interrupt enable
   localparam int          IC_NORM_EN      = 6;      // Normal interrupt enable
   localparam int          IC_PENDING      = 7;      // Interrupt pending flag
   // Local command fields
   localparam int          LC_SEND_DB      = 5;      // Outbound doorbell to remote
   localparam int          LC_CLR_RXDB     = 6;      // Clear incoming receiver doorbell
   localparam int          LC_CLR_ERR      = 7;      // Clear latched errors
   // Local status fields
   localparam int          LS_BUS_ERR      = 0;      // Remote bus error
   localparam int          LS_TIMEOUT      = 1;      // Interface timeout
   localparam int          LS_DATA_ERR     = 2;      // Interface data error
   localparam int          LS_RXDB         = 5;      // Incoming receiver doorbell
   // Remote command one fields
   localparam int          RC_IACK_LSB     = 0;      // Acknowledge level, bits 2..0
   localparam int          RC_SEND_RXDB    = 5;      // Receiver doorbell to remote
   localparam int          RC_ACK_TXDB     = 6;      // Acknowledge remote transmitter doorbell
   // Remote status fields
   localparam int          RS_RXDB_OUT     = 0;      // Receiver doorbell still pending at remote
   localparam int          RS_TXDB         = 1;      // Remote transmitter doorbell pending
   // DMA command fields
   localparam int          DC_DONE         = 1;      // DMA done flag
   localparam int          DC_DONE_EN      = 2;      // DMA done interrupt enable

   // Reset values
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [31:0] RST_WORD        = 32'h0000_0000;

   // Decode a three bit cable line code into lines 7..1; code zero selects none
   function automatic logic [7:1] ail_line_decode(input logic [2:0] code);
      logic [7:1] v;
      v = 7'h00;
      for (int i = 1; i < 8; i++) begin
         if (code == 3'(i)) begin
            v[i] = 1'b1;
         end
      end
      return v;
   endfunction
endpackage

// [hdl/ail_link_if.sv]
// Interface carrying the cable interrupt lines between host adapter and remote adapter
interface ail_link_if;
   logic [7:1] h2r_cable_irq_line;      // Host outbound doorbell on its selected line
   logic       h2r_rx_doorbell;         // Receiver doorbell toward remote, pulse
   logic       h2r_tx_doorbell_ack;     // Acknowledge of remote transmitter doorbell, pulse
   logic       h2r_iack_stb;            // Backplane acknowledge request, pulse
   logic [2:0] h2r_iack_level;          // Level being acknowledged
   logic [7:1] r2h_cable_irq_line;      // Remote levels and doorbell toward host
   logic       r2h_tx_doorbell;         // Remote transmitter doorbell pending, level
   logic       r2h_rx_doorbell;         // Receiver doorbell from remote, pulse
   logic       r2h_rx_doorbell_pend;    // Host receiver doorbell still pending at remote
   logic       r2h_bus_error;           // Remote backplane bus error, pulse

   // Host adapter end
   modport host_mp (
      output h2r_cable_irq_line, h2r_rx_doorbell, h2r_tx_doorbell_ack, h2r_iack_stb, h2r_iack_level,
      input  r2h_cable_irq_line, r2h_tx_doorbell, r2h_rx_doorbell, r2h_rx_doorbell_pend, r2h_bus_error
   );
   // Remote adapter end
   modport remote_mp (
      input  h2r_cable_irq_line, h2r_rx_doorbell, h2r_tx_doorbell_ack, h2r_iack_stb, h2r_iack_level,
      output r2h_cable_irq_line, r2h_tx_doorbell, r2h_rx_doorbell, r2h_rx_doorbell_pend, r2h_bus_error
   );
endinterface

// [hdl/ail_remote_end.sv]
// Remote adapter end: forwards backplane levels and doorbells over the cable lines
module ail_remote_end
   import ail_pkg::*;
(
   input  wire logic        clk_i,               // System clock
   input  wire logic        rst_i,               // Synchronous reset, active high
   input  wire logic [7:1]  backplane_irq_i,     // Backplane levels, asynchronous
   input  wire logic [7:1]  jumper_i,            // Level-pass jumpers, strap
   input  wire logic [2:0]  tx_db_line_i,        // Line code for doorbell to host
   input  wire logic        tx_db_send_i,        // Send transmitter doorbell to host, pulse
   input  wire logic        rx_db_send_i,        // Send receiver doorbell to host, pulse
   input  wire logic        rx_db_ack_i,         // Local acknowledge of host receiver doorbell
   input  wire logic        bus_error_i,         // Backplane bus error on host transfer, pulse
   output logic [7:1]       outbound_doorbell_irq_o, // Host doorbell levels seen on the cable
   output logic             receiver_doorbell_irq_o, // Host receiver doorbell pending
   output logic             iack_stb_o,          // Run a backplane acknowledge, pulse
   output logic [2:0]       iack_level_o,        // Level to acknowledge
   ail_link_if.remote_mp    link                 // Cable toward the host adapter
);

   logic [7:1] bp_meta_reg;      // First synchroniser stage
   logic [7:1] bp_sync_reg;      // Second synchroniser stage
   logic [7:1] jumper_reg;       // Jumpers caught while reset is held
   logic       txdb_reg;         // Transmitter doorbell pending
   logic [2:0] txdb_line_reg;    // Line carrying it

   // Two-stage synchroniser on backplane levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bp_meta_reg <= 7'h00;
         bp_sync_reg <= 7'h00;
      end else begin
         bp_meta_reg <= backplane_irq_i;
         bp_sync_reg <= bp_meta_reg;
      end
   end

   // Jumpers sampled while reset is held, kept afterwards
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         jumper_reg <= jumper_i;
      end
   end

   // Transmitter doorbell; a new send wins over the host acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txdb_reg      <= 1'b0;
         txdb_line_reg <= 3'h0;
      end else if (tx_db_send_i) begin
         txdb_reg      <= 1'b1;
         txdb_line_reg <= tx_db_line_i;
      end else if (link.h2r_tx_doorbell_ack) begin
         txdb_reg      <= 1'b0;
      end
   end

   // Host receiver doorbell held until acknowledged locally
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         receiver_doorbell_irq_o <= 1'b0;
      end else if (link.h2r_rx_doorbell) begin
         receiver_doorbell_irq_o <= 1'b1;
      end else if (rx_db_ack_i) begin
         receiver_doorbell_irq_o <= 1'b0;
      end
   end

   // Cable outputs toward the host, and local outputs taken from the cable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link.r2h_cable_irq_line <= 7'h00;
         link.r2h_rx_doorbell    <= 1'b0;
         link.r2h_bus_error      <= 1'b0;
         outbound_doorbell_irq_o <= 7'h00;
         iack_stb_o              <= 1'b0;
         iack_level_o            <= 3'h0;
      end else begin
         link.r2h_cable_irq_line <= (bp_sync_reg & jumper_reg) |
                                    (txdb_reg ? ail_line_decode(txdb_line_reg) : 7'h00);
         link.r2h_rx_doorbell    <= rx_db_send_i;
         link.r2h_bus_error      <= bus_error_i;
         outbound_doorbell_irq_o <= link.h2r_cable_irq_line;
         iack_stb_o              <= link.h2r_iack_stb;
         if (link.h2r_iack_stb) begin
            iack_level_o <= link.h2r_iack_level;
         end
      end
   end

   assign link.r2h_tx_doorbell      = txdb_reg;
   assign link.r2h_rx_doorbell_pend = receiver_doorbell_irq_o;
endmodule

// [tb/ail_link_chk.sv]
// Assertion checker watching the cable link between both adapter ends
module ail_link_chk (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [7:1] h2r_cable_irq_line,
   input wire logic       h2r_rx_doorbell,
   input wire logic       h2r_tx_doorbell_ack,
   input wire logic       h2r_iack_stb,
   input wire logic [7:1] r2h_cable_irq_line,
   input wire logic       r2h_tx_doorbell,
   input wire logic       r2h_rx_doorbell,
   input wire logic       r2h_rx_doorbell_pend,
   input wire logic       r2h_bus_error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Receiver doorbell sent, then seen pending at the far end
   sequence s_rxdb_sent; h2r_rx_doorbell; endsequence
   sequence s_pend_seen; ##[1:2] r2h_rx_doorbell_pend; endsequence
   a_line_onehot: assert property ($onehot0(h2r_cable_irq_line)) else $error("doorbell line not one-hot");
   a_rxdb_pend: assert property (s_rxdb_sent |-> s_pend_seen) else $error("doorbell not pending");
   a_rxdb_pulse: assert property (h2r_rx_doorbell |=> !h2r_rx_doorbell) else $error("long doorbell");
   a_txack_pulse: assert property (h2r_tx_doorbell_ack |=> !h2r_tx_doorbell_ack) else $error("long ack");
   a_txdb_cleared: assert property (h2r_tx_doorbell_ack |-> ##[1:2] !r2h_tx_doorbell) else $error("not cleared");
   a_iack_pulse: assert property (h2r_iack_stb |=> !h2r_iack_stb) else $error("long iack strobe");
   a_buserr_pulse: assert property (r2h_bus_error |=> !r2h_bus_error) else $error("long bus error");
   a_rxdb_in_pulse: assert property (r2h_rx_doorbell |=> !r2h_rx_doorbell) else $error("long doorbell in");
   a_txdb_line: assert property ($rose(r2h_tx_doorbell) |-> ##[0:1] (r2h_cable_irq_line != 7'h00))
      else $error("doorbell without line");
endmodule

// [tb/tb_adapter_interrupt_logic.sv]
// Self-checking bench joining host and remote adapter ends over the cable link
module tb_adapter_interrupt_logic
   import ail_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_i, cyc, stb, we, ack, inta_n, iack_stb, rxdb_irq;
   logic [7:0]  adr, ev;
   logic [31:0] wdat, rdat, q;
   logic [7:1]  bp, db_out;
   logic [2:0]  db_line, iack_lvl;
   int          errors, samples_checked;
   ail_link_if ail_link_if_inst ();
   ail_host_end ail_host_end_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .inta_n_o(inta_n),
      .xfer_start_i(ev[0]), .xfer_done_i(ev[1]), .data_error_i(ev[2]), .dma_done_i(ev[3]), .link(ail_link_if_inst));
   ail_remote_end ail_remote_end_inst (.clk_i(clk_i), .rst_i(rst_i), .backplane_irq_i(bp), .jumper_i(7'h55),
      .tx_db_line_i(db_line), .tx_db_send_i(ev[4]), .rx_db_send_i(ev[5]), .rx_db_ack_i(ev[6]), .bus_error_i(ev[7]),
      .outbound_doorbell_irq_o(db_out), .receiver_doorbell_irq_o(rxdb_irq), .iack_stb_o(iack_stb),
      .iack_level_o(iack_lvl), .link(ail_link_if_inst));
   ail_link_chk ail_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
      .h2r_cable_irq_line(ail_link_if_inst.h2r_cable_irq_line), .h2r_rx_doorbell(ail_link_if_inst.h2r_rx_doorbell),
      .h2r_tx_doorbell_ack(ail_link_if_inst.h2r_tx_doorbell_ack), .h2r_iack_stb(ail_link_if_inst.h2r_iack_stb),
      .r2h_cable_irq_line(ail_link_if_inst.r2h_cable_irq_line), .r2h_tx_doorbell(ail_link_if_inst.r2h_tx_doorbell),
      .r2h_rx_doorbell(ail_link_if_inst.r2h_rx_doorbell), .r2h_bus_error(ail_link_if_inst.r2h_bus_error),
      .r2h_rx_doorbell_pend(ail_link_if_inst.r2h_rx_doorbell_pend));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One classic Wishbone cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      q = rdat;
      // Remember whether the answer came before the bound ran out
      if (ack !== 1'b1) begin
         n = -1;
      end
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
      if (n < 0) begin
         errors++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   // One-cycle event pulse, then a gap cycle
   task automatic pulse(input int b);
      ev <= 8'h01 << b;
      @(posedge clk_i);
      ev <= 8'h00;
      @(posedge clk_i);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic irq(input logic e);
      chk({31'h0, inta_n}, {31'h0, e});
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Main sequence
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, adr, wdat, ev, bp, db_line} = '0;
      errors = 0;
      samples_checked = 0;
      wt(5);
      rst_i <= 1'b0;
      rd(OFS_INT_CTRL, 32'h0);
      irq(1'b1);
      rd(8'h20, 32'h0);
      for (int c = 0; c < 8; c++) begin
         wr(OFS_INT_CTRL, 8'(c));
         wr(OFS_LOCAL_CMD, 8'h20);
         wt(2);
         chk({25'h0, db_out}, 32'((9'h001 << c) >> 1));
         wr(OFS_LOCAL_CMD, 8'h00);
      end
      $display("test doorbell out done");
      bp <= 7'h7F;
      wt(5);
      rd(OFS_INT_STATUS, 32'hAA);
      irq(1'b1);
      wr(OFS_INT_CTRL, 8'h40);
      wt(1);
      irq(1'b0);
      rd(OFS_INT_CTRL, 32'hC0);
      wr(OFS_REMOTE_CMD1, 8'h07);
      rd(OFS_IACK_LOW, 32'h07);
      for (int i = 0; i < 10 && iack_stb !== 1'b1; i++) @(posedge clk_i);
      chk({28'h0, iack_stb, iack_lvl}, 32'hF);
      bp <= 7'h00;
      wt(5);
      irq(1'b1);
      rd(OFS_INT_CTRL, 32'h40);
      $display("test backplane done");
      pulse(5);
      wt(4);
      rd(OFS_LOCAL_STAT, 32'h20);
      irq(1'b0);
      wr(OFS_LOCAL_CMD, 8'h40);
      wt(1);
      rd(OFS_LOCAL_STAT, 32'h0);
      irq(1'b1);
      db_line <= 3'h2;
      pulse(4);
      wt(4);
      rd(OFS_REMOTE_STAT, 32'h02);
      rd(OFS_INT_STATUS, 32'h04);
      wr(OFS_REMOTE_CMD1, 8'h40);
      wt(4);
      rd(OFS_REMOTE_STAT, 32'h0);
      wr(OFS_REMOTE_CMD1, 8'h20);
      wt(3);
      chk({31'h0, rxdb_irq}, 32'h1);
      rd(OFS_REMOTE_STAT, 32'h01);
      pulse(6);
      wt(3);
      rd(OFS_REMOTE_STAT, 32'h0);
      $display("test doorbells done");
      pulse(7);
      pulse(2);
      wt(4);
      rd(OFS_LOCAL_STAT, 32'h05);
      irq(1'b1);
      wr(OFS_INT_CTRL, 8'h20);
      wt(1);
      irq(1'b0);
      wr(OFS_LOCAL_CMD, 8'h80);
      wt(1);
      rd(OFS_LOCAL_STAT, 32'h0);
      irq(1'b1);
      pulse(0);
      wt(2990);
      rd(OFS_LOCAL_STAT, 32'h0);
      wt(20);
      rd(OFS_LOCAL_STAT, 32'h02);
      irq(1'b0);
      wr(OFS_LOCAL_CMD, 8'h80);
      pulse(0);
      pulse(1);
      wt(3010);
      rd(OFS_LOCAL_STAT, 32'h0);
      irq(1'b1);
      $display("test errors done");
      wr(OFS_INT_CTRL, 8'h40);
      pulse(3);
      wt(2);
      rd(OFS_DMA_CMD, 32'h02);
      irq(1'b1);
      wr(OFS_DMA_CMD, 8'h04);
      pulse(3);
      wt(2);
      irq(1'b0);
      wr(OFS_INT_CTRL, 8'h00);
      wt(1);
      irq(1'b1);
      wr(OFS_INT_CTRL, 8'h40);
      wt(1);
      irq(1'b0);
      wr(OFS_DMA_CMD, 8'h04);
      wt(1);
      irq(1'b1);
      $display("test dma done");
      stop_test();
   end
endmodule
